// ==== eep_slave.sv ====
// Two-wire serial EEPROM slave: bus engine, write buffer and program timer
`timescale 1ns/1ps
// Notes on behaviour
// - Array is 2048 bytes, grouped in 16-byte pages.
// - Page writes take up to 32 bytes, wrapping in the 16-byte page; partial pages program only received bytes.
// - Programming cycle is self timed and ends within 5 ms.
// - Write-protect high makes the array read-only; reads still work.
// - Write-protect low lets writes change the array.
// - During power-on reset bus is ignored; on release machine restarts idle.
// - Power-on reset reasserting aborts any array write and goes standby.
// - Stop enters standby at once, or after a running program cycle.
// - Data line only pulled low, otherwise released.
// - Master makes the serial clock; all bit timing follows its edges.
// - Bytes come as select byte, then address, then data.
// - Select byte holds type field, three block bits, then read/write bit.
// - Start is data falling while clock high; idle until one is seen.
// - Select byte gets no acknowledge while a program cycle runs.
// - Page writes step only the low four address bits, wrapping.
module eep_slave
  import eep_pkg::*;
#(
  parameter logic [23:0] WrCycles = WR_CYCLES,
  parameter logic [3:0]  DevType  = DEV_TYPE_DFLT
) (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic porRstN,
  input  wire logic sclIn,
  input  wire logic sdaIn,
  output logic      sdaOut,
  output logic      sdaOeN,
  input  wire logic wpIn,
  output logic      busy,
  output logic      standby
);

  // ----------------------------------------
  // Input synchronisers and bus events
  // ----------------------------------------
  logic [1:0] sclSy_r, sdaSy_r, wpSy_r, porSy_r;
  logic       sclP_r, sdaP_r;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sclSy_r <= 2'h3;
      sdaSy_r <= 2'h3;
      wpSy_r  <= 2'h0;
      porSy_r <= 2'h0;
      sclP_r  <= 1'b1;
      sdaP_r  <= 1'b1;
    end else begin
      sclSy_r <= {sclSy_r[0], sclIn};
      sdaSy_r <= {sdaSy_r[0], sdaIn};
      wpSy_r  <= {wpSy_r[0], wpIn};
      porSy_r <= {porSy_r[0], porRstN};
      sclP_r  <= sclSy_r[1];
      sdaP_r  <= sdaSy_r[1];
    end
  end

  wire sclS    = sclSy_r[1];
  wire sdaS    = sdaSy_r[1];
  wire wpS     = wpSy_r[1];
  wire porOk   = porSy_r[1];
  wire sclRise = sclS & ~sclP_r;
  wire sclFall = ~sclS & sclP_r;
  wire startEv = sclS & sclP_r & sdaP_r & ~sdaS;
  wire stopEv  = sclS & sclP_r & ~sdaP_r & sdaS;

  // ----------------------------------------
  // Array and write buffer
  // ----------------------------------------
  logic [7:0] mem_r [MEM_BYTES];
  logic       busy_r, flush_r, sdaOeN_r, sdaOut_r, standby_r;
  logic [23:0] prgCnt_r;
  eep_wrreq_t pushReq, popReq;
  logic       push, fifoInReady, fifoOutValid;
  wire        drain = busy_r | flush_r;
  wire        memWe = busy_r & porOk & fifoOutValid;

  eep_fifo #(
    .WIDTH ($bits(eep_wrreq_t)),
    .DEPTH (FIFO_DEPTH)
  ) uBuf (
    .clk      (clk),
    .rstn     (rstn),
    .inValid  (push),
    .inReady  (fifoInReady),
    .inData   (pushReq),
    .outValid (fifoOutValid),
    .outReady (drain),
    .outData  (popReq)
  );

  // No reset: contents are nonvolatile
  always_ff @(posedge clk) begin
    if (memWe) begin
      mem_r[popReq.addr] <= popReq.data;
    end
  end

  // ----------------------------------------
  // Bus engine
  // ----------------------------------------
  eep_bus_st_t       st_r, st_nxt;
  eep_kind_t         kind_r, kind_nxt;
  logic [3:0]        cnt_r, cnt_nxt;
  logic [7:0]        rxSh_r, rxSh_nxt, txSh_r, txSh_nxt;
  logic [ADDR_W-1:0] ptr_r, ptr_nxt;
  logic [2:0]        blk_r, blk_nxt;
  logic              rdOp_r, rdOp_nxt, oeN_nxt;

  wire [7:0] memRd   = mem_r[ptr_r];
  wire       devHit  = rxSh_r[7:SEL_TYPE_LSB] == DevType;
  wire       devAck  = devHit & ~busy_r & ~flush_r;
  // A full buffer refuses the data byte, so the master sees a NACK
  wire       ackOk   = (kind_r == BK_DEV) ? devAck : (kind_r == BK_DATA) ? fifoInReady : 1'b1;
  wire [ADDR_W-1:0] pageNext = {ptr_r[ADDR_W-1:PAGE_W], ptr_r[PAGE_W-1:0] + 4'h1};

  assign pushReq = '{addr: ptr_r, data: rxSh_r};

  always_comb begin
    st_nxt   = st_r;
    kind_nxt = kind_r;
    cnt_nxt  = cnt_r;
    rxSh_nxt = rxSh_r;
    txSh_nxt = txSh_r;
    ptr_nxt  = ptr_r;
    blk_nxt  = blk_r;
    rdOp_nxt = rdOp_r;
    oeN_nxt  = sdaOeN_r;
    push     = 1'b0;
    if (!porOk) begin
      st_nxt  = ST_IDLE;
      oeN_nxt = 1'b1;
    end else if (startEv) begin
      st_nxt   = ST_RX;
      kind_nxt = BK_DEV;
      cnt_nxt  = BIT_CNT_RST;
      oeN_nxt  = 1'b1;
    end else if (stopEv) begin
      st_nxt  = ST_IDLE;
      oeN_nxt = 1'b1;
    end else begin
      unique case (st_r)
        ST_IDLE: begin
        end
        ST_RX: begin
          if (sclRise && cnt_r != BITS_PER_BYTE) begin
            rxSh_nxt = {rxSh_r[6:0], sdaS};
            cnt_nxt  = cnt_r + 4'h1;
          end else if (sclFall && cnt_r == BITS_PER_BYTE) begin
            st_nxt  = ST_ACK;
            oeN_nxt = ~ackOk;
            if (ackOk) begin
              unique case (kind_r)
                BK_DEV: begin
                  blk_nxt  = rxSh_r[SEL_BLK_LSB+:3];
                  rdOp_nxt = rxSh_r[0];
                  if (!rxSh_r[0]) begin
                    kind_nxt = BK_ADDR;
                  end
                end
                BK_ADDR: begin
                  ptr_nxt  = {blk_r, rxSh_r};
                  kind_nxt = BK_DATA;
                end
                BK_DATA: begin
                  push    = 1'b1;
                  ptr_nxt = pageNext;
                end
                default: begin
                end
              endcase
            end
          end
        end
        ST_ACK: begin
          if (sclFall) begin
            cnt_nxt = BIT_CNT_RST;
            if (sdaOeN_r) begin
              st_nxt = ST_IDLE;
            end else if (rdOp_r && kind_r == BK_DEV) begin
              st_nxt   = ST_TX;
              txSh_nxt = memRd;
              oeN_nxt  = memRd[7];
            end else begin
              st_nxt  = ST_RX;
              oeN_nxt = 1'b1;
            end
          end
        end
        ST_TX: begin
          if (sclFall) begin
            if (cnt_r == BITS_PER_BYTE - 4'h1) begin
              st_nxt  = ST_MACK;
              oeN_nxt = 1'b1;
            end else begin
              txSh_nxt = {txSh_r[6:0], 1'b0};
              oeN_nxt  = txSh_r[6];
              cnt_nxt  = cnt_r + 4'h1;
            end
          end
        end
        ST_MACK: begin
          if (sclRise) begin
            ptr_nxt = ptr_r + 11'h001;
            if (sdaS) begin
              st_nxt = ST_IDLE;
            end
          end else if (sclFall) begin
            st_nxt   = ST_TX;
            cnt_nxt  = BIT_CNT_RST;
            txSh_nxt = memRd;
            oeN_nxt  = memRd[7];
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r     <= ST_IDLE;
      kind_r   <= BK_DEV;
      cnt_r    <= BIT_CNT_RST;
      rxSh_r   <= 8'h00;
      txSh_r   <= 8'h00;
      ptr_r    <= PTR_RST;
      blk_r    <= 3'h0;
      rdOp_r   <= 1'b0;
      sdaOeN_r <= 1'b1;
    end else begin
      st_r     <= st_nxt;
      kind_r   <= kind_nxt;
      cnt_r    <= cnt_nxt;
      rxSh_r   <= rxSh_nxt;
      txSh_r   <= txSh_nxt;
      ptr_r    <= ptr_nxt;
      blk_r    <= blk_nxt;
      rdOp_r   <= rdOp_nxt;
      sdaOeN_r <= oeN_nxt;
    end
  end

  // ----------------------------------------
  // Program timer and standby
  // ----------------------------------------
  // Buffer drains into the array in the first cycles of the timed window
  wire stopGo = stopEv & porOk & ~busy_r & ~flush_r & fifoOutValid;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busy_r    <= 1'b0;
      flush_r   <= 1'b0;
      prgCnt_r  <= 24'h000000;
      sdaOut_r  <= 1'b0;
      standby_r <= 1'b1;
    end else begin
      sdaOut_r  <= 1'b0;
      standby_r <= ~porOk | ((st_r == ST_IDLE) & ~busy_r & ~flush_r);
      if (!porOk) begin
        busy_r  <= 1'b0;
        flush_r <= 1'b1;
      end else if (stopGo) begin
        busy_r   <= ~wpS;
        flush_r  <= wpS;
        prgCnt_r <= 24'h000000;
      end else begin
        if (busy_r) begin
          prgCnt_r <= prgCnt_r + 24'h000001;
          if (prgCnt_r == WrCycles - 24'h000001) begin
            busy_r <= 1'b0;
          end
        end
        if (flush_r && !fifoOutValid) begin
          flush_r <= 1'b0;
        end
      end
    end
  end

  assign sdaOut  = sdaOut_r;
  assign sdaOeN  = sdaOeN_r;
  assign busy    = busy_r;
  assign standby = standby_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  AST_OPEN_DRAIN: assert property (sdaOut == 1'b0)
    else $error("Data line driven high");
  AST_PRG_BOUND: assert property (busy_r |-> prgCnt_r < WrCycles)
    else $error("Program cycle overran");
  AST_WP_NO_PRG: assert property (stopEv && wpS |=> !$rose(busy_r))
    else $error("Program cycle began while protected");
  AST_WE_ONLY_BUSY: assert property (memWe |-> busy_r && porOk)
    else $error("Array written outside program cycle");
  AST_POR_IDLE: assert property (!porOk |=> st_r == ST_IDLE && !busy_r && sdaOeN_r)
    else $error("Bus active during power-on reset");
  AST_POR_ABORT: assert property (busy_r && !porOk |=> !busy_r ##1 !memWe)
    else $error("Write continued under power-on reset");
  AST_STOP_STBY: assert property (stopEv && porOk && !busy_r && !fifoOutValid && !flush_r |-> ##[1:3] standby_r)
    else $error("No standby after stop");
  AST_BUSY_NACK: assert property (st_r == ST_RX && kind_r == BK_DEV && sclFall && cnt_r == BITS_PER_BYTE
                                  && busy_r && !startEv && !stopEv && porOk |=> sdaOeN_r)
    else $error("Select byte acknowledged while busy");
  AST_PAGE_WRAP: assert property (push |=> ptr_r[ADDR_W-1:PAGE_W] == $past(ptr_r[ADDR_W-1:PAGE_W]))
    else $error("Page write moved upper address bits");
  AST_IDLE_START: assert property (st_r == ST_IDLE && !startEv |=> st_r == ST_IDLE)
    else $error("Left idle without start");

endmodule : eep_slave

// ==== eep_pkg.sv ====
// Shared constants and types for the serial EEPROM slave
package eep_pkg;

  // ----------------------------------------
  // Array organisation
  // ----------------------------------------
  localparam int unsigned MEM_BYTES  = 2048;
  localparam int unsigned ADDR_W     = 11;
  localparam int unsigned PAGE_W     = 4;
  localparam int unsigned FIFO_DEPTH = 32;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned T_WR_NS       = 5000000;
  // Longest time, so rounded down
  localparam logic [23:0] WR_CYCLES     = 24'(T_WR_NS / CLK_PERIOD_NS);

  // ----------------------------------------
  // Select byte and reset values
  // ----------------------------------------
  // Arbitrary value, not taken from any real part
  localparam logic [3:0] DEV_TYPE_DFLT = 4'h6;
  localparam int unsigned SEL_TYPE_LSB = 4;
  localparam int unsigned SEL_BLK_LSB  = 1;
  localparam logic [3:0] BIT_CNT_RST   = 4'h0;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [ADDR_W-1:0] PTR_RST = 11'h000;

  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_MACK} eep_bus_st_t;
  typedef enum logic [1:0] {BK_DEV, BK_ADDR, BK_DATA} eep_kind_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0]        data;
  } eep_wrreq_t;

endpackage : eep_pkg

// ==== eep_fifo.sv ====
// Write buffer FIFO with valid/ready on both sides
`timescale 1ns/1ps
module eep_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store_r [DEPTH];
  logic [AW:0]      wrPtr_r;
  logic [AW:0]      rdPtr_r;
  wire              doPush = inValid & inReady;
  wire              doPop  = outValid & outReady;

  assign inReady  = (wrPtr_r[AW] == rdPtr_r[AW]) || (wrPtr_r[AW-1:0] != rdPtr_r[AW-1:0]);
  assign outValid = wrPtr_r != rdPtr_r;
  assign outData  = store_r[rdPtr_r[AW-1:0]];

  always_ff @(posedge clk) begin
    if (doPush) begin
      store_r[wrPtr_r[AW-1:0]] <= inData;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
    end else begin
      wrPtr_r <= wrPtr_r + (AW+1)'(doPush);
      rdPtr_r <= rdPtr_r + (AW+1)'(doPop);
    end
  end
endmodule : eep_fifo

// ==== eep_master.sv ====
// Two-wire bus master model that drives the EEPROM slave
`timescale 1ns/1ps
module eep_master (
  input  wire logic       clk,
  input  wire logic       sdaIn,
  output logic            scl,
  output logic            sdaOeN,
  output logic            resTgl,
  output logic      [7:0] resVal
);
  // ----
  // Bus primitives
  // ----
  initial begin
    scl    = 1'b1;
    sdaOeN = 1'b1;
    resTgl = 1'b0;
    resVal = 8'h00;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  // Data moves late in the low phase, so a slow release is never seen as a Stop
  task automatic slot(input logic b, output logic s);
    scl = 1'b0;
    tick(5);
    sdaOeN = b;
    tick(1);
    scl = 1'b1;
    tick(2);
    s = sdaIn;
  endtask : slot
  task automatic start();
    logic s;
    slot(1'b1, s);
    tick(2);
    sdaOeN = 1'b0;
    tick(4);
  endtask : start
  task automatic stop();
    logic s;
    slot(1'b0, s);
    tick(2);
    sdaOeN = 1'b1;
    tick(4);
  endtask : stop
  // ----
  // Byte transfers
  // ----
  task automatic put(input logic [7:0] v);
    resVal = v;
    resTgl = ~resTgl;
  endtask : put
  task automatic wr_byte(input logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) slot(d[i], s);
    slot(1'b1, s);
    put({7'h00, s});
  endtask : wr_byte
  task automatic rd_byte(input logic last);
    logic [7:0] d;
    logic       s;
    for (int i = 7; i >= 0; i--) begin
      slot(1'b1, s);
      d[i] = s;
    end
    slot(last, s);
    put(d);
  endtask : rd_byte
endmodule : eep_master

// ==== eep_slave_bench.sv ====
// Self-checking bench for the EEPROM slave against a bus master model
`timescale 1ns/1ps
module eep_slave_bench;
  import eep_pkg::*;
  // Short program time, still above a full buffer flush
  localparam logic [23:0] WR_SHORT = 24'h0000C8;
  logic       clk, rstn, porRstN, wpIn;
  logic       scl, mOeN, sdaOut, sdaOeN, busy, standby, resTgl, seenTgl = 1'b0;
  logic [7:0] resVal;
  logic [7:0] expQ[$];
  logic [7:0] mem [0:2047];
  wire        sdaWire = mOeN & (sdaOeN | sdaOut);
  int         num_errors = 0, n_tests = 0, cyc = 0;
  int         base, off;
  always #12.5 clk = ~clk;
  eep_slave #(.WrCycles(WR_SHORT), .DevType(DEV_TYPE_DFLT)) i_eep_slave (.clk(clk), .rstn(rstn),
    .porRstN(porRstN), .sclIn(scl), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOeN(sdaOeN), .wpIn(wpIn),
    .busy(busy), .standby(standby));
  eep_master i_eep_master (.clk(clk), .sdaIn(sdaWire), .scl(scl), .sdaOeN(mOeN), .resTgl(resTgl),
    .resVal(resVal));
  // ----
  // Checking and closing
  // ----
  always @(posedge clk) begin
    cyc++;
    if (resTgl !== seenTgl) begin
      seenTgl = resTgl;
      n_tests++;
      if (expQ.size() == 0 || resVal !== expQ[0]) begin
        num_errors++;
        $display("mismatch at %0t: bus result %h", $time, resVal);
      end
      if (expQ.size() != 0) void'(expQ.pop_front());
    end
    if (cyc == 40000) begin
      num_errors++;
      $display("mismatch at %0t: run hangs", $time);
      results();
    end
  end
  task automatic results();
    if (num_errors == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results
  task automatic cmp(input logic g, input logic e);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch at %0t: status %b expected %b", $time, g, e);
    end
  endtask : cmp
  task automatic wr(input logic [7:0] b, input logic ack);
    expQ.push_back({7'h00, ack});
    i_eep_master.wr_byte(b);
  endtask : wr
  task automatic sel(input logic rw, input logic [2:0] blk, input logic ack);
    wr({DEV_TYPE_DFLT, blk, rw}, ack);
  endtask : sel
  // ----
  // Scenarios
  // ----
  // mode 0 normal, 1 protected, 2 aborted by power-on reset
  task automatic write_run(input int a, input int n, input int mode);
    logic [7:0] d;
    time        t0;
    int         el;
    wpIn = (mode == 1);
    i_eep_master.start();
    sel(1'b0, a[10:8], 1'b0);
    wr(a[7:0], 1'b0);
    for (int k = 0; k < n; k++) begin
      d = 8'($urandom());
      wr(d, k >= 32);
      if (mode == 0 && k < 32) mem[{a[10:4], 4'(a[3:0] + k)}] = d;
    end
    i_eep_master.stop();
    t0 = $time;
    i_eep_master.tick(4);
    cmp(busy, mode != 1);
    if (mode == 2) begin
      porRstN = 1'b0;
      i_eep_master.tick(6);
      cmp(busy, 1'b0);
      cmp(standby, 1'b1);
      i_eep_master.start();
      sel(1'b0, 3'h0, 1'b1);
      i_eep_master.stop();
      porRstN = 1'b1;
      i_eep_master.tick(8);
    end else begin
      i_eep_master.start();
      sel(1'b0, 3'h0, mode == 0);
      i_eep_master.stop();
      cmp(standby, mode == 1);
      while (busy === 1'b1 && $time - t0 < 400 * 25) i_eep_master.tick(1);
      el = int'(($time - t0) / 25);
      if (mode == 0) cmp(el >= 195 && el <= 206, 1'b1);
      i_eep_master.tick(2);
      cmp(standby, 1'b1);
    end
  endtask : write_run
  task automatic read_run(input int a, input int n);
    i_eep_master.start();
    sel(1'b0, a[10:8], 1'b0);
    wr(a[7:0], 1'b0);
    i_eep_master.start();
    sel(1'b1, a[10:8], 1'b0);
    for (int k = 0; k < n; k++) begin
      expQ.push_back(mem[11'(a + k)]);
      i_eep_master.rd_byte(k == n - 1);
    end
    i_eep_master.stop();
    i_eep_master.tick(4);
    cmp(standby, 1'b1);
  endtask : read_run
  initial begin
    clk     = 1'b0;
    rstn    = 1'b0;
    porRstN = 1'b1;
    wpIn    = 1'b0;
    void'($urandom(38877));
    repeat (5) @(negedge clk);
    rstn = 1'b1;
    i_eep_master.tick(6);
    cmp(standby, 1'b1);
    cmp(sdaOeN, 1'b1);
    wr({DEV_TYPE_DFLT, 4'h0}, 1'b1);
    base = int'({3'($urandom()), 4'($urandom()), 4'h0});
    off = int'($urandom() % 16);
    write_run(base, 33, 0);
    write_run(base + off, 1 + int'($urandom() % 16), 0);
    write_run(base, 16, 1);
    wpIn = 1'b0;
    read_run(base, 15);
    i_eep_master.start();
    sel(1'b1, 3'h0, 1'b0);
    expQ.push_back(mem[11'(base + 15)]);
    i_eep_master.rd_byte(1'b1);
    i_eep_master.stop();
    i_eep_master.start();
    wr({~DEV_TYPE_DFLT, 4'h0}, 1'b1);
    i_eep_master.stop();
    write_run(11'(base + 16), 4, 2);
    results();
  end
endmodule : eep_slave_bench
